// >>> design/bel_pkg.sv
// Package with constants and types for the boot download sequencer
package bel_pkg;
    localparam logic [3:0]  EEPROM_ADDR_HI = 4'hA;     // Upper address pattern 1010
    localparam logic [2:0]  EEPROM_ADDR_LO = 3'h0;     // Low bits: chip select, unused; the strap input supplies them
    localparam logic [15:0] CSUM_SUBADDR   = 16'h0000; // Checksum word location
    localparam int          HDR_BYTES      = 8;
    localparam int          READ_TRIES     = 3;
    localparam int          BLOCK_TRIES    = 3;
    localparam int          CLK_MHZ        = 100;
    localparam int          SCL_KHZ        = 375;
    localparam int          QTR_DIV        = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam logic [7:0]  QTR_DIV_W      = 8'(QTR_DIV);
    localparam logic [1:0]  MEM_PROG       = 2'h0;
    localparam logic [1:0]  MEM_COEF       = 2'h1;
    localparam logic [1:0]  MEM_DATA       = 2'h2;

    typedef enum logic [1:0] {
        BEL_CMD_START = 2'b00,
        BEL_CMD_WRITE = 2'b01,
        BEL_CMD_READ  = 2'b10,
        BEL_CMD_STOP  = 2'b11
    } bel_cmd_type;

    typedef enum logic [3:0] {
        BEL_IDLE    = 4'b0000,
        BEL_ADDRW   = 4'b0001,
        BEL_SUBHI   = 4'b0010,
        BEL_SUBLO   = 4'b0011,
        BEL_RSTART  = 4'b0100,
        BEL_ADDRR   = 4'b0101,
        BEL_HEADER  = 4'b0110,
        BEL_PAYLOAD = 4'b0111,
        BEL_ENDSUM  = 4'b1000,
        BEL_STOP    = 4'b1001,
        BEL_DONE    = 4'b1010,
        BEL_FAIL    = 4'b1011,
        BEL_CSUM    = 4'b1100
    } bel_state_type;
endpackage

// >>> design/bel_byte_master.sv
// Two-wire bus byte engine: start, stop, byte write and byte read
`timescale 1ns/1ps
module bel_byte_master
    import bel_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              cmd_valid_in,
    input  wire bel_pkg::bel_cmd_type cmd_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              ack_in,
    output logic                   busy_out,
    output logic                   done_out,
    output logic [7:0]             rdata_out,
    output logic                   nack_out,
    input  wire logic              scl_in,
    output logic                   scl_out,
    output logic                   scl_oe_n_out,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n_out
);
    import bel_pkg::*;

    logic [7:0]  div_cnt;
    logic        tick;
    logic [1:0]  phase;
    logic [3:0]  bit_idx;
    logic [8:0]  shreg;
    bel_cmd_type cmd;
    logic        scl_low;
    logic        sda_low;

    assign scl_out      = 1'b0;
    assign sda_out      = 1'b0;
    // Open drain: enable low while pulling the wire low
    assign scl_oe_n_out = ~scl_low;
    assign sda_oe_n_out = ~sda_low;
    assign tick         = (div_cnt == 8'h00);

    always_ff @(posedge clk_in) begin
        if (srst_in || !busy_out || tick) begin
            div_cnt <= QTR_DIV_W - 8'h01;
        end else begin
            div_cnt <= div_cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            busy_out  <= 1'b0;
            done_out  <= 1'b0;
            phase     <= 2'h0;
            bit_idx   <= 4'h0;
            shreg     <= 9'h000;
            cmd       <= BEL_CMD_STOP;
            scl_low   <= 1'b0;
            sda_low   <= 1'b0;
            rdata_out <= 8'h00;
            nack_out  <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (!busy_out) begin
                if (cmd_valid_in) begin
                    busy_out <= 1'b1;
                    cmd      <= cmd_in;
                    phase    <= 2'h0;
                    bit_idx  <= 4'h0;
                    // Ninth bit is our acknowledge on reads, released on writes
                    shreg    <= (cmd_in == BEL_CMD_READ) ? {8'hFF, ~ack_in} : {wdata_in, 1'b1};
                end
            end else if (tick) begin
                phase <= phase + 2'h1;
                unique case (cmd)
                    BEL_CMD_START: begin
                        unique case (phase)
                            2'h0: begin scl_low <= 1'b0; sda_low <= 1'b0; end
                            2'h1: sda_low <= 1'b1;
                            2'h2: scl_low <= 1'b1;
                            2'h3: begin busy_out <= 1'b0; done_out <= 1'b1; end
                        endcase
                    end
                    BEL_CMD_STOP: begin
                        unique case (phase)
                            2'h0: begin scl_low <= 1'b1; sda_low <= 1'b1; end
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b0;
                            2'h3: begin busy_out <= 1'b0; done_out <= 1'b1; end
                        endcase
                    end
                    default: begin
                        unique case (phase)
                            2'h0: begin scl_low <= 1'b1; sda_low <= ~shreg[8]; end
                            2'h1: scl_low <= 1'b0;
                            2'h2: shreg <= {shreg[7:0], sda_in};
                            2'h3: begin
                                scl_low <= 1'b1;
                                bit_idx <= bit_idx + 4'h1;
                                // SDA is left as it is: releasing it here would race the falling SCL
                                if (bit_idx == 4'h8) begin
                                    busy_out  <= 1'b0;
                                    done_out  <= 1'b1;
                                    rdata_out <= shreg[8:1];
                                    nack_out  <= (cmd == BEL_CMD_WRITE) && shreg[0];
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end
endmodule

// >>> design/bel_boot_loader.sv
// Boot download sequencer: loads memories from a serial EEPROM after reset
//
// Summary of operation
// - After reset the slave control port is off and the master port runs the download.
// - The loader probes for an EEPROM at bus address 1010xxx, xxx chosen by a strap input.
// - Each valid header is followed by a data block copied to program, coefficient or data memory.
// - A header whose data length is zero ends the download.
// - On success the master port is disabled, the slave port enabled and audio starts.
// - On no answer or a failed read the slave port takes over and the ROM default is used.
// - Under the ROM default, audio is passed straight through while the GPIO input is low.
// - Master and slave ports are never active together.
// - A failed header or byte read is tried three times in all before giving up.
// - A checksum mismatch rereads the end header and ending word from blk_start up to two more times before giving up.
// - The checksum word at subaddress 0 must equal both the ending word and the running sum.
// - Reads use start, write address, subaddress, repeated start, read address, acked bytes.
`timescale 1ns/1ps
module bel_boot_loader
    import bel_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [2:0]  eeprom_sel_in,
    input  wire logic        gpio_in,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n_out,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n_out,
    output logic             master_en_out,
    output logic             slave_en_out,
    output logic             mem_we_out,
    output logic [1:0]       mem_sel_out,
    output logic [15:0]      mem_addr_out,
    output logic [7:0]       mem_data_out,
    output logic             load_done_out,
    output logic             default_cfg_out,
    output logic             audio_bypass_out
);
    import bel_pkg::*;

    bel_state_type state;
    bel_cmd_type   cmd;
    logic          cmd_valid;
    logic [7:0]    wdata;
    logic          ack;
    logic          busy;
    logic          done;
    logic [7:0]    rdata;
    logic          nack;
    logic [15:0]   sub;
    logic [15:0]   blk_start;
    logic [15:0]   blk_sum_start;
    logic [15:0]   sum;
    logic [15:0]   csum_ref;
    logic [15:0]   end_word;
    logic [63:0]   hdr;
    logic [3:0]    hcnt;
    logic [15:0]   len;
    logic [1:0]    read_tries;
    logic [1:0]    blk_tries;
    logic          issued;
    logic          first;
    bel_state_type end_state;

    function automatic logic [7:0] addr_byte(input logic [2:0] sel, input logic rd);
        addr_byte = {EEPROM_ADDR_HI, sel, rd};
    endfunction

    bel_byte_master u_byte (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .cmd_valid_in (cmd_valid),
        .cmd_in       (cmd),
        .wdata_in     (wdata),
        .ack_in       (ack),
        .busy_out     (busy),
        .done_out     (done),
        .rdata_out    (rdata),
        .nack_out     (nack),
        .scl_in       (scl_in),
        .scl_out      (scl_out),
        .scl_oe_n_out (scl_oe_n_out),
        .sda_in       (sda_in),
        .sda_out      (sda_out),
        .sda_oe_n_out (sda_oe_n_out)
    );

    // Port enables are decoded from one state so they cannot overlap
    assign master_en_out    = (state != BEL_DONE) && (state != BEL_FAIL);
    assign slave_en_out     = ~master_en_out;
    assign load_done_out    = (state == BEL_DONE);
    assign default_cfg_out  = (state == BEL_FAIL);
    assign audio_bypass_out = default_cfg_out && !gpio_in;
    assign cmd_valid        = master_en_out && !busy && !done && !issued;
    assign len              = hdr[15:0];

    always_comb begin
        cmd   = BEL_CMD_WRITE;
        wdata = 8'h00;
        ack   = 1'b1;
        unique case (state)
            BEL_IDLE, BEL_RSTART: cmd = BEL_CMD_START;
            BEL_ADDRW: wdata = addr_byte(eeprom_sel_in, 1'b0);
            BEL_SUBHI: wdata = sub[15:8];
            BEL_SUBLO: wdata = sub[7:0];
            BEL_ADDRR: wdata = addr_byte(eeprom_sel_in, 1'b1);
            BEL_PAYLOAD, BEL_CSUM: cmd = BEL_CMD_READ;
            BEL_HEADER: begin
                // Refuse the last byte of a bad header so that a stop can follow
                cmd = BEL_CMD_READ;
                ack = !((hcnt == 4'(HDR_BYTES - 1)) && (hdr[55:54] == 2'h3));
            end
            BEL_ENDSUM: begin
                cmd = BEL_CMD_READ;
                ack = (hcnt == 4'h0);
            end
            default: cmd = BEL_CMD_STOP;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            issued <= 1'b0;
        end else if (cmd_valid) begin
            issued <= 1'b1;
        end else if (done) begin
            issued <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        mem_we_out <= 1'b0;
        if (srst_in) begin
            state         <= BEL_IDLE;
            sub           <= CSUM_SUBADDR;
            blk_start     <= CSUM_SUBADDR;
            blk_sum_start <= 16'h0000;
            sum           <= 16'h0000;
            csum_ref      <= 16'h0000;
            end_word      <= 16'h0000;
            hdr           <= 64'h0;
            hcnt          <= 4'h0;
            read_tries    <= 2'h0;
            blk_tries     <= 2'h0;
            first         <= 1'b1;
            end_state     <= BEL_IDLE;
            mem_sel_out   <= MEM_PROG;
            mem_addr_out  <= 16'h0000;
            mem_data_out  <= 8'h00;
        end else if (done) begin
            unique case (state)
                BEL_IDLE:   state <= BEL_ADDRW;
                BEL_RSTART: state <= BEL_ADDRR;
                BEL_ADDRW, BEL_SUBHI, BEL_SUBLO, BEL_ADDRR: begin
                    if (nack) begin
                        // No answer: retry the whole access, then give up
                        if (read_tries == 2'(READ_TRIES - 1)) begin
                            end_state <= BEL_FAIL;
                            state     <= BEL_STOP;
                        end else begin
                            read_tries <= read_tries + 2'h1;
                            state      <= BEL_STOP;
                        end
                    end else if (state == BEL_ADDRW) begin
                        state <= BEL_SUBHI;
                    end else if (state == BEL_SUBHI) begin
                        state <= BEL_SUBLO;
                    end else if (state == BEL_SUBLO) begin
                        state <= BEL_RSTART;
                    end else if (first) begin
                        state <= BEL_CSUM;
                    end else begin
                        state <= BEL_HEADER;
                    end
                end
                BEL_CSUM: begin
                    csum_ref <= {csum_ref[7:0], rdata};
                    sub      <= sub + 16'h0001;
                    hcnt     <= hcnt + 4'h1;
                    if (hcnt == 4'h1) begin
                        hcnt  <= 4'h0;
                        first <= 1'b0;
                        state <= BEL_HEADER;
                        blk_start     <= sub + 16'h0001;
                        blk_sum_start <= 16'h0000;
                    end
                end
                BEL_HEADER: begin
                    hdr  <= {hdr[55:0], rdata};
                    sum  <= sum + {8'h00, rdata};
                    sub  <= sub + 16'h0001;
                    hcnt <= hcnt + 4'h1;
                    if (hcnt == 4'(HDR_BYTES - 1)) begin
                        hcnt         <= 4'h0;
                        mem_sel_out  <= hdr[55:54];
                        mem_addr_out <= hdr[47:32];
                        read_tries   <= 2'h0;
                        if ({hdr[7:0], rdata} == 16'h0000) begin
                            state <= BEL_ENDSUM;
                        end else if (hdr[55:54] == 2'h3) begin
                            // Invalid target memory is treated as a bad header
                            if (read_tries == 2'(READ_TRIES - 1)) begin
                                end_state <= BEL_FAIL;
                                state     <= BEL_STOP;
                            end else begin
                                read_tries <= read_tries + 2'h1;
                                sub        <= blk_start;
                                sum        <= blk_sum_start;
                                state      <= BEL_STOP;
                            end
                        end else begin
                            state <= BEL_PAYLOAD;
                        end
                    end
                end
                BEL_PAYLOAD: begin
                    mem_we_out   <= 1'b1;
                    mem_data_out <= rdata;
                    sum          <= sum + {8'h00, rdata};
                    sub          <= sub + 16'h0001;
                    if (hcnt != 4'h0 || sub != blk_start + 16'(HDR_BYTES)) begin
                        mem_addr_out <= mem_addr_out + 16'h0001;
                    end
                    hcnt <= 4'h1;
                    if (sub + 16'h0001 == blk_start + 16'(HDR_BYTES) + len) begin
                        hcnt          <= 4'h0;
                        blk_start     <= sub + 16'h0001;
                        blk_sum_start <= sum + {8'h00, rdata};
                        blk_tries     <= 2'h0;
                        state         <= BEL_HEADER;
                    end
                end
                BEL_ENDSUM: begin
                    end_word <= {end_word[7:0], rdata};
                    hcnt     <= hcnt + 4'h1;
                    if (hcnt == 4'h1) begin
                        hcnt <= 4'h0;
                        // All three words must agree
                        if (csum_ref == {end_word[7:0], rdata} && csum_ref == sum) begin
                            end_state <= BEL_DONE;
                            state     <= BEL_STOP;
                        end else if (blk_tries == 2'(BLOCK_TRIES - 1)) begin
                            end_state <= BEL_FAIL;
                            state     <= BEL_STOP;
                        end else begin
                            blk_tries <= blk_tries + 2'h1;
                            sub       <= blk_start;
                            sum       <= blk_sum_start;
                            state     <= BEL_STOP;
                        end
                    end
                end
                // Every pass ends in a stop, so the bus is never left clamped low
                BEL_STOP: state <= end_state;
                BEL_DONE, BEL_FAIL: state <= state;
            endcase
        end
    end

    a_ports_exclusive: assert property (@(posedge clk_in) disable iff (srst_in)
        master_en_out != slave_en_out)
        else $error("master and slave ports both active or both idle");
    a_reset_master: assert property (@(posedge clk_in)
        $fell(srst_in) |-> master_en_out && !slave_en_out)
        else $error("master port not enabled after reset");
    a_bypass_gpio: assert property (@(posedge clk_in) disable iff (srst_in)
        default_cfg_out && !gpio_in |-> audio_bypass_out)
        else $error("default config without pass-through on low gpio");
    a_done_sticky: assert property (@(posedge clk_in) disable iff (srst_in)
        load_done_out |=> load_done_out && slave_en_out)
        else $error("completion state left before reset");
    a_fail_sticky: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(default_cfg_out) |-> !master_en_out ##1 default_cfg_out)
        else $error("fallback does not hand over to slave");
    a_zero_len_end: assert property (@(posedge clk_in) disable iff (srst_in)
        state == BEL_HEADER && done && hcnt == 4'h7 && {hdr[7:0], rdata} == 16'h0000
        |=> state == BEL_ENDSUM)
        else $error("zero length header did not end download");
    a_write_target: assert property (@(posedge clk_in) disable iff (srst_in)
        mem_we_out |-> $past(state) == BEL_PAYLOAD && mem_sel_out != 2'h3)
        else $error("memory write outside payload");
    a_tries_bound: assert property (@(posedge clk_in) disable iff (srst_in)
        read_tries != 2'h3 && blk_tries != 2'h3)
        else $error("retry count overran");
    a_bus_released: assert property (@(posedge clk_in) disable iff (srst_in)
        !master_en_out |-> scl_oe_n_out && sda_oe_n_out)
        else $error("bus not released after the download");
endmodule

// >>> verification/bel_eeprom_model.sv
// Behavioural two-wire serial EEPROM that answers at 1010 plus a select field
`timescale 1ns/1ps
module bel_eeprom_model (
    input  wire logic       rst_in,
    input  wire logic       present_in,
    input  wire logic [2:0] sel_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe_n_out,
    output logic [7:0]      addr_seen_out
);
    logic [7:0]  mem [0:31];
    logic [1:0]  mode;
    logic [3:0]  bit_n;
    logic [7:0]  shreg;
    logic [1:0]  byte_n;
    logic [15:0] ptr;
    logic        rd;

    // Image: checksum word, one two-byte coefficient block, end header, ending checksum
    initial begin
        foreach (mem[k]) begin
            mem[k] = 8'h00;
        end
        mem[0] = 8'h01;
        mem[1] = 8'h83;
        mem[2] = 8'h40;
        mem[3] = 8'h01;
        mem[4] = 8'h23;
        mem[9] = 8'h02;
        mem[10] = 8'h5A;
        mem[11] = 8'hC3;
        mem[20] = 8'h01;
        mem[21] = 8'h83;
        sda_oe_n_out = 1'b1;
        addr_seen_out = 8'h00;
        mode = 2'd0;
        bit_n = 4'd0;
        byte_n = 2'd0;
        ptr = 16'h0000;
        rd = 1'b0;
    end

    always @(posedge rst_in) begin
        mode = 2'd0;
        sda_oe_n_out = 1'b1;
    end

    // Start and repeated start restart the frame without a stop
    always @(negedge sda_in) begin
        if (scl_in === 1'b1) begin
            mode = 2'd1;
            bit_n = 4'd0;
            byte_n = 2'd0;
        end
    end

    always @(posedge sda_in) begin
        if (scl_in === 1'b1) begin
            mode = 2'd0;
            sda_oe_n_out = 1'b1;
        end
    end

    always @(posedge scl_in) begin
        if (mode != 2'd0 && bit_n < 4'd8) begin
            if (mode == 2'd1) begin
                shreg = {shreg[6:0], sda_in};
            end
            bit_n = bit_n + 4'd1;
        end else if (mode == 2'd2 && bit_n == 4'd8 && sda_in !== 1'b0) begin
            mode = 2'd0;
        end else if (mode != 2'd0 && bit_n == 4'd8) begin
            bit_n = 4'd9;
        end
    end

    // Data changes only while the clock is low; released lines float to the pull-up
    always @(negedge scl_in) begin
        if (mode == 2'd1 && bit_n == 4'd9) begin
            sda_oe_n_out = 1'b1;
            bit_n = 4'd0;
            if (rd) begin
                mode = 2'd2;
                bit_n = 4'd9;
            end
        end
        if (mode == 2'd1 && bit_n == 4'd8) begin
            if (byte_n == 2'd0) begin
                addr_seen_out = shreg;
                rd = shreg[0];
                if (!present_in || shreg[7:1] != {4'hA, sel_in}) begin
                    mode = 2'd0;
                end
            end else if (byte_n == 2'd1) begin
                ptr[15:8] = shreg;
            end else begin
                ptr[7:0] = shreg;
            end
            if (mode == 2'd1) begin
                sda_oe_n_out = 1'b0;
            end
            byte_n = (byte_n == 2'd3) ? 2'd3 : byte_n + 2'd1;
        end
        if (mode == 2'd2) begin
            if (bit_n == 4'd9) begin
                shreg = mem[ptr[4:0]];
                ptr = ptr + 16'd1;
                bit_n = 4'd0;
            end
            sda_oe_n_out = (bit_n < 4'd8) ? shreg[3'd7 - bit_n[2:0]] : 1'b1;
        end
    end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the boot download sequencer
`timescale 1ns/1ps
module tb_top;
    import bel_pkg::*;
    logic        clk_in;
    logic        srst_in;
    logic [2:0]  eeprom_sel_in;
    logic        gpio_in;
    logic        present;
    logic [2:0]  mdl_sel;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        scl_o;
    logic        sda_o;
    logic        mdl_sda_oe_n;
    logic        scl_wire;
    logic        sda_wire;
    logic [7:0]  addr_seen;
    logic        master_en;
    logic        slave_en;
    logic        mem_we;
    logic [1:0]  mem_sel;
    logic [15:0] mem_addr;
    logic [7:0]  mem_data;
    logic        load_done;
    logic        default_cfg;
    logic        bypass;
    logic [25:0] wr_q [$];
    int          err_total;
    int          checks;

    // Wired-AND with pull-ups; the EEPROM never stretches the clock
    assign scl_wire = scl_oe_n;
    assign sda_wire = sda_oe_n & mdl_sda_oe_n;

    bel_boot_loader i_dut (
        .clk_in           (clk_in),
        .srst_in          (srst_in),
        .eeprom_sel_in    (eeprom_sel_in),
        .gpio_in          (gpio_in),
        .scl_in           (scl_wire),
        .scl_out          (scl_o),
        .scl_oe_n_out     (scl_oe_n),
        .sda_in           (sda_wire),
        .sda_out          (sda_o),
        .sda_oe_n_out     (sda_oe_n),
        .master_en_out    (master_en),
        .slave_en_out     (slave_en),
        .mem_we_out       (mem_we),
        .mem_sel_out      (mem_sel),
        .mem_addr_out     (mem_addr),
        .mem_data_out     (mem_data),
        .load_done_out    (load_done),
        .default_cfg_out  (default_cfg),
        .audio_bypass_out (bypass)
    );

    bel_eeprom_model i_eeprom (
        .rst_in        (srst_in),
        .present_in    (present),
        .sel_in        (mdl_sel),
        .scl_in        (scl_wire),
        .sda_in        (sda_wire),
        .sda_oe_n_out  (mdl_sda_oe_n),
        .addr_seen_out (addr_seen)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (mem_we === 1'b1) begin
            wr_q.push_back({mem_sel, mem_addr, mem_data});
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic start_run(input logic pres, input logic [2:0] msel, input logic [2:0] dsel);
        @(posedge clk_in);
        #1;
        srst_in = 1'b1;
        present = pres;
        mdl_sel = msel;
        eeprom_sel_in = dsel;
        gpio_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        wr_q.delete();
    endtask

    // Bounded wait for either outcome of the download
    task automatic wait_end(input int limit);
        int n;
        n = 0;
        while (load_done !== 1'b1 && default_cfg !== 1'b1 && n < limit) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check(32'(n < limit), 32'd1);
    endtask

    task automatic t_boot_load;
        start_run(1'b1, 3'h5, 3'h5);
        check(32'(master_en), 32'd1);
        check(32'(slave_en), 32'd0);
        wait_end(70000);
        check(32'(load_done), 32'd1);
        check(32'(default_cfg), 32'd0);
        check(32'(master_en), 32'd0);
        check(32'(slave_en), 32'd1);
        check(32'({scl_o, sda_o, scl_wire, sda_wire}), 32'h3);
        check(32'(bypass), 32'd0);
        check(32'(addr_seen), {24'h0, 4'hA, 3'h5, 1'b1});
        check(32'(wr_q.size()), 32'd2);
        check(32'(wr_q[0]), 32'({MEM_COEF, 16'h0123, 8'h5A}));
        check(32'(wr_q[1]), 32'({MEM_COEF, 16'h0124, 8'hC3}));
    endtask

    task automatic t_no_eeprom;
        start_run(1'b0, 3'h5, 3'h5);
        wait_end(20000);
        check(32'(default_cfg), 32'd1);
        check(32'(load_done), 32'd0);
        check(32'(master_en), 32'd0);
        check(32'(slave_en), 32'd1);
        check(32'({scl_wire, sda_wire}), 32'h3);
        check(32'(wr_q.size()), 32'd0);
        check(32'(bypass), 32'd1);
        @(posedge clk_in);
        #1;
        gpio_in = 1'b1;
        @(posedge clk_in);
        #1;
        check(32'(bypass), 32'd0);
    endtask

    // EEPROM strapped to another select value must not be taken for ours
    task automatic t_wrong_select;
        start_run(1'b1, 3'h5, 3'h2);
        wait_end(20000);
        check(32'(default_cfg), 32'd1);
        check(32'(addr_seen), {24'h0, 4'hA, 3'h2, 1'b0});
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        srst_in = 1'b1;
        eeprom_sel_in = 3'h0;
        gpio_in = 1'b0;
        present = 1'b0;
        mdl_sel = 3'h0;
        err_total = 0;
        checks = 0;
        t_no_eeprom();
        t_wrong_select();
        t_boot_load();
        report_and_stop();
    end

    // Full run is roughly 80k cycles; the margin covers slower retry spacing
    initial begin
        repeat (98000) @(posedge clk_in);
        err_total++;
        report_and_stop();
    end
endmodule
